//--- design/lhp_host_port.sv
// Purpose: decode host strobes into read, data write and command write
// Assumes: straps tied, pins asynchronous to sys_clk
// Notes: one operation is taken per strobe assertion
//
// Behaviour
// RULE1: The strap field chooses one of three bus styles and is static.
// RULE2: Separate strobes: read sel1 rd0 wr1, data sel0 wr0, cmd sel1 wr0.
// RULE3: Enable high: read sel1 dir1, data sel0 dir0, cmd sel1 dir0.
// RULE4: Direction plus low strobe: same decode as with enable, strobe low.
// RULE5: The host wires select to its address bit zero.
// RULE6: Count parameters are stored as value minus one.
// RULE7: The host programs bytes per line rounded up from pixel width over 8.
// RULE8: The host programs total addresses per line at least bytes plus 2.
// RULE9: The frame clock divider is 4, 8 or 16 only.
// RULE10: Pixels right of the last whole character field are blanked.
// RULE11: Data writes after a command fill its parameters in order.
`timescale 1ns/1ps
`include "lhp_defs.svh"
module lhp_host_port (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [4:0] bus_config_straps,
  input  wire logic       cmd_data_select,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] data_in,
  input  wire logic [7:0] rd_data,
  input  wire logic [1:0] sysclk_divider,
  input  wire logic [3:0] char_field_width,
  input  wire logic [3:0] pixel_in_field,
  input  wire logic       pixel_in,
  input  wire logic       last_field,
  input  wire logic [3:0] pixels_left,
  output logic [7:0]      data_out,
  output logic            data_oe,
  output logic            rd_pulse,
  output logic            data_wr_pulse,
  output logic            cmd_wr_pulse,
  output logic [7:0]      cmd_out,
  output logic [3:0]      param_idx,
  output logic [7:0]      wr_data,
  output logic            frame_tick,
  output logic            pixel_out
);
  logic [2:0] sel_s1_reg, sel_s2_reg;
  logic [2:0] sel_s_next;
  logic [7:0] din_s1_reg, din_s2_reg;
  lhp_pkg::lhp_pins_t pins;
  logic [2:0] style_reg, style_next;
  logic       strap_done_reg, strap_done_next;
  lhp_pkg::lhp_op_t op_now;
  logic       active_prev_reg, active_now;
  logic [7:0] cmd_reg, cmd_next;
  logic [3:0] idx_reg, idx_next;
  logic [7:0] dout_reg, dout_next;
  logic       oe_reg, oe_next;
  logic       rdp_reg, rdp_next, dwp_reg, dwp_next, cwp_reg, cwp_next;
  logic [7:0] wdat_reg, wdat_next;
  logic       pix_reg, pix_next;
  logic       tick_w, tick_reg;
  logic [4:0] field_px;

  // Two flops on every pin before decode
  always_comb begin
    sel_s_next = {cmd_data_select, rd_n, wr_n};
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sel_s1_reg <= 3'b011;
      sel_s2_reg <= 3'b011;
      din_s1_reg <= 8'h00;
      din_s2_reg <= 8'h00;
    end else begin
      sel_s1_reg <= sel_s_next;
      sel_s2_reg <= sel_s1_reg;
      din_s1_reg <= data_in;
      din_s2_reg <= din_s1_reg;
    end
  end

  assign pins = sel_s2_reg;

  // Straps caught once after reset release, never followed afterwards
  always_comb begin
    style_next      = style_reg;
    strap_done_next = 1'b1;
    if (!strap_done_reg) begin
      style_next = bus_config_straps[`LHP_STYLE_MSB:`LHP_STYLE_LSB]; // RULE1
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      style_reg      <= `LHP_STYLE_SEP;
      strap_done_reg <= 1'b0;
    end else begin
      style_reg      <= style_next;
      strap_done_reg <= strap_done_next;
    end
  end

  // Decode per style; rd_n pin carries enable or strobe in other styles
  always_comb begin
    op_now = lhp_pkg::LHP_OP_NONE;
    unique case (style_reg)
      `LHP_STYLE_RWE: begin
        if (pins.rd_n) begin
          if (pins.sel && pins.wr_n)
            op_now = lhp_pkg::LHP_OP_READ; // RULE3
          else if (!pins.sel && !pins.wr_n)
            op_now = lhp_pkg::LHP_OP_DATA; // RULE3
          else if (pins.sel && !pins.wr_n)
            op_now = lhp_pkg::LHP_OP_CMD;  // RULE3
        end
      end
      `LHP_STYLE_RWDS: begin
        if (!pins.rd_n) begin
          if (pins.sel && pins.wr_n)
            op_now = lhp_pkg::LHP_OP_READ; // RULE4
          else if (!pins.sel && !pins.wr_n)
            op_now = lhp_pkg::LHP_OP_DATA; // RULE4
          else if (pins.sel && !pins.wr_n)
            op_now = lhp_pkg::LHP_OP_CMD;  // RULE4
        end
      end
      default: begin
        if (pins.sel && !pins.rd_n && pins.wr_n)
          op_now = lhp_pkg::LHP_OP_READ; // RULE2
        else if (!pins.sel && pins.rd_n && !pins.wr_n)
          op_now = lhp_pkg::LHP_OP_DATA; // RULE2
        else if (pins.sel && pins.rd_n && !pins.wr_n)
          op_now = lhp_pkg::LHP_OP_CMD;  // RULE2
      end
    endcase
    active_now = (op_now != lhp_pkg::LHP_OP_NONE);
  end

  // Act on the first cycle of each strobe; a held strobe counts once
  always_comb begin
    cmd_next  = cmd_reg;
    idx_next  = idx_reg;
    dout_next = dout_reg;
    wdat_next = wdat_reg;
    rdp_next  = 1'b0;
    dwp_next  = 1'b0;
    cwp_next  = 1'b0;
    oe_next   = (op_now == lhp_pkg::LHP_OP_READ);
    if (oe_next)
      dout_next = rd_data;
    if (active_now && !active_prev_reg) begin
      unique case (op_now)
        lhp_pkg::LHP_OP_READ: rdp_next = 1'b1;
        lhp_pkg::LHP_OP_DATA: begin
          dwp_next  = 1'b1;
          wdat_next = din_s2_reg;
        end
        lhp_pkg::LHP_OP_CMD: begin
          cwp_next  = 1'b1;
          cmd_next  = din_s2_reg;
          idx_next  = 4'h0; // RULE11
        end
        default: ;
      endcase
    end
    if (dwp_reg && idx_reg != 4'hF)
      idx_next = idx_reg + 4'h1; // RULE11
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      active_prev_reg <= 1'b0;
      cmd_reg         <= 8'h00;
      idx_reg         <= 4'h0;
      dout_reg        <= 8'h00;
      oe_reg          <= 1'b0;
      rdp_reg         <= 1'b0;
      dwp_reg         <= 1'b0;
      cwp_reg         <= 1'b0;
      wdat_reg        <= 8'h00;
    end else begin
      active_prev_reg <= active_now;
      cmd_reg         <= cmd_next;
      idx_reg         <= idx_next;
      dout_reg        <= dout_next;
      oe_reg          <= oe_next;
      rdp_reg         <= rdp_next;
      dwp_reg         <= dwp_next;
      cwp_reg         <= cwp_next;
      wdat_reg        <= wdat_next;
    end
  end

  lhp_clk_div u_div (
    .sys_clk (sys_clk),
    .rst     (rst),
    .sel     (sysclk_divider),
    .tick    (tick_w)
  );

  // Field width is stored minus one; blank partial field at line end
  assign field_px = {1'b0, char_field_width} + 5'(`LHP_WIDTH_OFFSET); // RULE6

  always_comb begin
    pix_next = pixel_in;
    if (last_field && ({1'b0, pixel_in_field} >= {1'b0, pixels_left}))
      pix_next = 1'b0; // RULE10
    if ({1'b0, pixel_in_field} >= field_px)
      pix_next = 1'b0;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pix_reg  <= 1'b0;
      tick_reg <= 1'b0;
    end else begin
      pix_reg  <= pix_next;
      tick_reg <= tick_w;
    end
  end

  assign data_out      = dout_reg;
  assign data_oe       = oe_reg;
  assign rd_pulse      = rdp_reg;
  assign data_wr_pulse = dwp_reg;
  assign cmd_wr_pulse  = cwp_reg;
  assign cmd_out       = cmd_reg;
  assign param_idx     = idx_reg;
  assign wr_data       = wdat_reg;
  assign frame_tick    = tick_reg;
  assign pixel_out     = pix_reg;

  property p_cmd_resets_idx;
    @(posedge sys_clk) disable iff (rst)
      cwp_reg |-> idx_reg == 4'h0;
  endproperty
  a_cmd_resets_idx: assert property (p_cmd_resets_idx) // RULE11
    else $error("param index not cleared by command");

  property p_data_advances;
    @(posedge sys_clk) disable iff (rst)
      (dwp_reg && idx_reg != 4'hF) |=> idx_reg == $past(idx_reg) + 4'h1;
  endproperty
  a_data_advances: assert property (p_data_advances) // RULE11
    else $error("param index did not advance");

  property p_sep_cmd;
    @(posedge sys_clk) disable iff (rst)
      (style_reg == `LHP_STYLE_SEP && cwp_reg) |->
        $past(pins.sel) && !$past(pins.wr_n) && $past(pins.rd_n);
  endproperty
  a_sep_cmd: assert property (p_sep_cmd) // RULE2
    else $error("separate style command decode wrong");

  property p_rwe_read;
    @(posedge sys_clk) disable iff (rst)
      (style_reg == `LHP_STYLE_RWE && rdp_reg) |->
        $past(pins.rd_n) && $past(pins.sel) && $past(pins.wr_n);
  endproperty
  a_rwe_read: assert property (p_rwe_read) // RULE3
    else $error("enable style read decode wrong");

  property p_rwds_data;
    @(posedge sys_clk) disable iff (rst)
      (style_reg == `LHP_STYLE_RWDS && dwp_reg) |->
        !$past(pins.rd_n) && !$past(pins.sel) && !$past(pins.wr_n);
  endproperty
  a_rwds_data: assert property (p_rwds_data) // RULE4
    else $error("strobe style data decode wrong");

  property p_style_static;
    @(posedge sys_clk) disable iff (rst)
      strap_done_reg |=> $stable(style_reg);
  endproperty
  a_style_static: assert property (p_style_static) // RULE1
    else $error("bus style changed after capture");

  property p_one_pulse;
    @(posedge sys_clk) disable iff (rst)
      (rdp_reg || dwp_reg || cwp_reg) |=> !(rdp_reg || dwp_reg || cwp_reg);
  endproperty
  a_one_pulse: assert property (p_one_pulse) // RULE2
    else $error("operation pulse longer than one cycle");

  property p_blank;
    @(posedge sys_clk) disable iff (rst)
      (last_field && pixel_in_field >= pixels_left) |=> !pix_reg;
  endproperty
  a_blank: assert property (p_blank) // RULE10
    else $error("leftover pixel not blanked");

  property p_tick_gap;
    @(posedge sys_clk) disable iff (rst)
      (tick_reg && sysclk_divider == `LHP_DIV_4) |=> !tick_reg [*3];
  endproperty
  a_tick_gap: assert property (p_tick_gap) // RULE9
    else $error("divide by 4 tick spacing wrong");

  c_read: cover property (@(posedge sys_clk) rdp_reg);
  c_cmd_then_data: cover property (@(posedge sys_clk)
    cwp_reg ##[1:40] dwp_reg);
  c_blank: cover property (@(posedge sys_clk) last_field && !pix_reg);
endmodule : lhp_host_port

//--- design/lhp_defs.svh
// Purpose: constants for the LCD controller host bus port
// Assumes: 8-bit host data bus, straps static after reset
// Notes: strap field sits in bits 4:2 of the strap word
`ifndef LHP_DEFS_SVH
`define LHP_DEFS_SVH
`define LHP_STYLE_LSB      2
`define LHP_STYLE_MSB      4
`define LHP_STYLE_SEP      3'h0
`define LHP_STYLE_RWE      3'h1
`define LHP_STYLE_RWDS     3'h2
`define LHP_DIV_4          2'h0
`define LHP_DIV_8          2'h1
`define LHP_DIV_16         2'h2
`define LHP_DIV_4_CNT      5'h04
`define LHP_DIV_8_CNT      5'h08
`define LHP_DIV_16_CNT     5'h10
`define LHP_WIDTH_OFFSET   4'h1
`define LHP_BITS_PER_BYTE  8
`define LHP_TOTAL_MARGIN   2
`endif

//--- design/lhp_pkg.sv
// Purpose: types for the LCD controller host bus port
// Assumes: lhp_defs.svh holds all numbers
// Notes: none
package lhp_pkg;
  typedef enum logic [2:0] {
    LHP_SEP  = 3'b000,
    LHP_RWE  = 3'b001,
    LHP_RWDS = 3'b010
  } lhp_style_t;

  typedef enum logic [1:0] {
    LHP_OP_NONE = 2'b00,
    LHP_OP_READ = 2'b01,
    LHP_OP_DATA = 2'b10,
    LHP_OP_CMD  = 2'b11
  } lhp_op_t;

  typedef struct packed {
    logic       sel;
    logic       rd_n;
    logic       wr_n;
  } lhp_pins_t;

  typedef struct packed {
    lhp_op_t    op;
    logic [7:0] cmd;
    logic [3:0] param_idx;
    logic [7:0] data;
  } lhp_req_t;
endpackage : lhp_pkg

//--- design/lhp_clk_div.sv
// Purpose: frame timing tick from the system clock by 4, 8 or 16
// Assumes: sel is stable between frames
// Notes: illegal selector codes fall back to divide by 4
`timescale 1ns/1ps
`include "lhp_defs.svh"
module lhp_clk_div (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [1:0] sel,
  output logic            tick
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [4:0] limit;
  logic       tick_reg;
  logic       tick_next;

  always_comb begin
    unique case (sel)
      `LHP_DIV_8:  limit = `LHP_DIV_8_CNT;  // RULE9
      `LHP_DIV_16: limit = `LHP_DIV_16_CNT; // RULE9
      default:     limit = `LHP_DIV_4_CNT;  // RULE9
    endcase
    // Compare with >= so a smaller divider chosen mid-count does not
    // send the counter round its full range
    tick_next = (cnt_reg >= limit - 5'h01);
    cnt_next  = tick_next ? 5'h00 : cnt_reg + 5'h01;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 5'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule : lhp_clk_div

//--- testbench/lhp_host_model.sv
// Purpose: host processor model driving the port's bus pins
// Assumes: style input matches the straps given to the port
// Notes: released select and data pins toggle so stale values never look valid
`timescale 1ns/1ps
module lhp_host_model (
  input  wire logic       sys_clk,
  input  wire logic [2:0] style,
  output logic            cmd_data_select,
  output logic            rd_n,
  output logic            wr_n,
  output logic [7:0]      data_in
);
  logic busy = 1'b0;

  initial begin
    cmd_data_select = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 8'h00;
  end

  // Idle bus: address and data lines belong to other traffic
  always @(posedge sys_clk) begin
    if (!busy) begin
      rd_n <= (style == 3'h1) ? 1'b0 : 1'b1;
      wr_n <= 1'b1;
      cmd_data_select <= ~cmd_data_select;
      data_in <= ~data_in;
    end
  end

  // NONE drives both strobes low in separate-strobe style
  task automatic op(input lhp_pkg::lhp_op_t kind, input logic [7:0] val);
    logic [15:0] addr;
    addr = {15'h0010, kind != lhp_pkg::LHP_OP_DATA};
    busy = 1'b1;
    @(posedge sys_clk);
    cmd_data_select <= addr[0];
    data_in <= val;
    wr_n <= (kind == lhp_pkg::LHP_OP_READ);
    if (style == 3'h1 || style == 3'h2) begin
      rd_n <= (style == 3'h1);
    end else begin
      rd_n <= !(kind == lhp_pkg::LHP_OP_READ ||
                kind == lhp_pkg::LHP_OP_NONE);
    end
    repeat (5) @(posedge sys_clk);
    rd_n <= (style == 3'h1) ? 1'b0 : 1'b1;
    wr_n <= 1'b1;
    data_in <= ~val;
    // Recovery gap well beyond the one idle cycle the port needs
    repeat (4) @(posedge sys_clk);
    busy = 1'b0;
  endtask : op
endmodule : lhp_host_model

//--- testbench/testbench.sv
// Purpose: self-checking bench for the host bus port
// Assumes: one op at a time, partner holds strobes five cycles
// Notes: each bus style is entered through a fresh reset
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    lhp_pkg::lhp_op_t op;
    logic [7:0]       val;
    logic [3:0]       idx;
  } lhp_row_t;
  lhp_row_t rows [4] = '{'{lhp_pkg::LHP_OP_CMD, 8'h40, 4'h0},
    '{lhp_pkg::LHP_OP_DATA, 8'h38, 4'h0},
    '{lhp_pkg::LHP_OP_DATA, 8'h87, 4'h1},
    '{lhp_pkg::LHP_OP_READ, 8'h5a, 4'h0}};
  // Host-side line sizing for a 40 character line of 8 pixel fields
  localparam int line_chars = 40;
  localparam int char_px    = 8;
  localparam int line_bytes = (line_chars * char_px + 7) / 8;
  localparam int line_total = line_bytes + 2;
  // Last field, width minus one, position, pixels left; odd rows blank
  logic [12:0] px [4] = '{13'h0b50, 13'h0560, 13'h1a12, 13'h1a54};
  logic [7:0] div_exp [4] = '{8'h04, 8'h08, 8'h10, 8'h04};
  logic sys_clk = 1'b0, rst = 1'b1;
  logic [4:0] bus_config_straps = 5'h00;
  logic [2:0] host_style = 3'h0;
  logic sel, rd_n, wr_n, data_oe, rd_pulse, data_wr_pulse, cmd_wr_pulse;
  logic frame_tick, pixel_out, last_field = 1'b0, pixel_in = 1'b1;
  logic oe_seen = 1'b0;
  logic [7:0] data_in, data_out, cmd_out, wr_data, rd_data = 8'h00;
  logic [7:0] n_pulse = 8'h00, n0, period = 8'h00, tick_cnt = 8'h00;
  logic [1:0] sysclk_divider = 2'h0;
  logic [3:0] char_field_width = 4'h0, pixel_in_field = 4'h0;
  logic [3:0] pixels_left = 4'h0, param_idx, last_idx = 4'h0;
  lhp_pkg::lhp_op_t last_op = lhp_pkg::LHP_OP_NONE;
  int miscompares = 0, checks = 0, cycles = 0;

  always #12.5 sys_clk = ~sys_clk;

  lhp_host_model lhp_host_model_i (.sys_clk(sys_clk), .style(host_style),
    .cmd_data_select(sel), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in));

  lhp_host_port lhp_host_port_i (.sys_clk(sys_clk), .rst(rst),
    .bus_config_straps(bus_config_straps), .cmd_data_select(sel),
    .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in), .rd_data(rd_data),
    .sysclk_divider(sysclk_divider), .char_field_width(char_field_width),
    .pixel_in_field(pixel_in_field), .pixel_in(pixel_in),
    .last_field(last_field), .pixels_left(pixels_left),
    .data_out(data_out), .data_oe(data_oe), .rd_pulse(rd_pulse),
    .data_wr_pulse(data_wr_pulse), .cmd_wr_pulse(cmd_wr_pulse),
    .cmd_out(cmd_out), .param_idx(param_idx), .wr_data(wr_data),
    .frame_tick(frame_tick), .pixel_out(pixel_out));

  task automatic conclude;
    if (miscompares == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic do_reset(input logic [2:0] style);
    rst <= 1'b1;
    bus_config_straps <= {style, 2'b00};
    host_style <= style;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
  endtask : do_reset

  // Pulse census; a held strobe must add exactly one
  always @(posedge sys_clk) begin
    if (cmd_wr_pulse | data_wr_pulse | rd_pulse) n_pulse <= n_pulse + 8'h01;
    if (cmd_wr_pulse) last_op <= lhp_pkg::LHP_OP_CMD;
    if (data_wr_pulse) last_op <= lhp_pkg::LHP_OP_DATA;
    if (rd_pulse) last_op <= lhp_pkg::LHP_OP_READ;
    if (data_wr_pulse) last_idx <= param_idx;
    if (data_oe) oe_seen <= 1'b1;
    if (frame_tick) begin
      period <= tick_cnt;
      tick_cnt <= 8'h01;
    end else begin
      tick_cnt <= tick_cnt + 8'h01;
    end
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic run_op(input lhp_row_t row);
    rd_data <= row.val;
    oe_seen = 1'b0;
    n0 = n_pulse;
    lhp_host_model_i.op(row.op, row.val);
    check(n_pulse - n0, 8'h01);
    check({6'h00, last_op}, {6'h00, row.op});
    case (row.op)
      lhp_pkg::LHP_OP_CMD: check(cmd_out, row.val);
      lhp_pkg::LHP_OP_DATA: begin
        check(wr_data, row.val);
        check({4'h0, last_idx}, {4'h0, row.idx});
      end
      default: begin
        check(data_out, row.val);
        check({7'h00, oe_seen}, 8'h01);
        check({7'h00, data_oe}, 8'h00);
      end
    endcase
  endtask : run_op

  initial begin
    for (int s = 0; s < 3; s++) begin
      do_reset(3'(s));
      for (int r = 0; r < 4; r++) begin
        run_op('{rows[r].op, rows[r].val ^ 8'(s), rows[r].idx});
      end
    end
    // New command restarts the parameter sequence
    // Line sizes go in as count minus one
    run_op('{lhp_pkg::LHP_OP_CMD, 8'h44, 4'h0});
    run_op('{lhp_pkg::LHP_OP_DATA, 8'(line_bytes - 1), 4'h0});
    run_op('{lhp_pkg::LHP_OP_DATA, 8'(line_total - 1), 4'h1});
    do_reset(3'h0);
    n0 = n_pulse;
    lhp_host_model_i.op(lhp_pkg::LHP_OP_NONE, 8'h11);
    check(n_pulse - n0, 8'h00);
    // Straps moved after reset must not change the decode; a separate
    // style read carries no enable, so it would vanish if they did
    bus_config_straps <= {3'h1, 2'b00};
    run_op('{lhp_pkg::LHP_OP_READ, 8'h4c, 4'h0});
    for (int d = 0; d < 4; d++) begin
      sysclk_divider <= 2'(d);
      repeat (40) @(posedge sys_clk);
      check(period, div_exp[d]);
    end
    for (int p = 0; p < 4; p++) begin
      {last_field, char_field_width, pixel_in_field, pixels_left} <=
        px[p][12:0];
      repeat (3) @(posedge sys_clk);
      check({7'h00, pixel_out}, {7'h00, p[0] == 1'b0});
    end
    conclude();
  end
endmodule : testbench
